//--- logic/rtc_trim_pkg.sv
package rtc_trim_pkg;

  // register offsets on the device port
  localparam logic [5:0] OFS_OUT_CTRL = 6'h08;
  localparam logic [5:0] OFS_ITR = 6'h0b;
  localparam logic [5:0] OFS_COLD = 6'h0c;
  localparam logic [5:0] OFS_STEP = 6'h0d;
  localparam logic [5:0] OFS_XTO = 6'h2c;
  localparam logic [5:0] OFS_HOT = 6'h2d;

  // field positions
  localparam int COMP_EN_BIT = 7;
  localparam int BATT_EN_BIT = 6;
  localparam int BATT_RATE_BIT = 5;
  localparam logic [3:0] FREQ_SEL_1024 = 4'h3;
  localparam logic [7:0] OUT_CTRL_1024 = 8'h03;
  localparam logic [5:0] MID_TRIM = 6'h20;
  localparam logic [1:0] COARSE_UP = 2'h3;
  localparam logic [1:0] COARSE_DOWN = 2'h1;
  localparam logic [1:0] COARSE_NONE = 2'h0;

  // device reset values
  localparam logic [7:0] RST_OUT_CTRL = 8'h00;
  localparam logic [7:0] RST_ITR = 8'h20;
  localparam logic [7:0] RST_COEF = 8'h46;
  localparam logic [7:0] RST_STEP = 8'h00;
  localparam logic [7:0] RST_XTO = 8'h00;

  // errors in 1/16 ppm
  localparam logic signed [15:0] COARSE_HI = 16'sh01f0;
  localparam logic signed [15:0] COARSE_LO = -16'sh0200;
  localparam logic signed [15:0] COARSE_STEP = 16'sh01e8;
  // analog step sizes in 1/16 ppm per code
  localparam logic [5:0] STEP_MIN = 6'h08;
  localparam logic [5:0] STEP_UNIT = 6'h10;
  localparam logic [5:0] STEP_MAX = 6'h20;
  localparam logic [16:0] EXTREME_SPAN = 17'h0003f;
  localparam logic [6:0] FINE_MID = 7'h20;
  localparam logic [6:0] FINE_MAX = 7'h3f;
  // curvature: q16 input, times 2048 gives a right shift by 5
  localparam int ALPHA_SHIFT = 5;
  localparam logic [15:0] ALPHA_ROUND = 16'h0010;

  // temperatures in half degrees celsius
  localparam logic signed [9:0] TURN_BASE = 10'sh032;
  localparam logic signed [9:0] TEMP_MIN = -10'sh050;
  localparam logic signed [9:0] TEMP_MAX = 10'sh0aa;

  // timing
  localparam int CLK_HZ = 10_000_000;
  localparam int FOUT_HZ = 1024;
  localparam int FOUT_HALF_CYC = CLK_HZ / (2 * FOUT_HZ);
  localparam int GATE_TIME_MS = 1000;
  localparam int GATE_CYC = (CLK_HZ / 1000) * GATE_TIME_MS;

  function automatic logic [4:0] xto_encode(logic signed [9:0] t);
    logic signed [9:0] d;
    d = t - TURN_BASE;
    if (d >= 0)
      xto_encode = (d > 10'sd15) ? 5'h0f : {1'b0, d[3:0]};
    else
      xto_encode = (-d > 10'sd15) ? 5'h1f : {1'b1, 4'(-d)};
  endfunction : xto_encode

  function automatic logic signed [9:0] xto_decode(logic [4:0] c);
    if (c[4])
      xto_decode = TURN_BASE - 10'($unsigned(c[3:0]));
    else
      xto_decode = TURN_BASE + 10'($unsigned(c[3:0]));
  endfunction : xto_decode

  // span between extremes over 63, rounded
  function automatic logic [5:0] pick_step(logic signed [15:0] a,
                                           logic signed [15:0] b);
    logic signed [16:0] diff;
    logic [16:0] mag;
    logic [16:0] q;
    diff = 17'(a) - 17'(b);
    mag = (diff < 0) ? 17'(-diff) : 17'(diff);
    q = (mag + (EXTREME_SPAN >> 1)) / EXTREME_SPAN;
    if (q < 17'(STEP_MIN))
      pick_step = STEP_MIN;
    else if (q > 17'(STEP_MAX))
      pick_step = STEP_MAX;
    else
      pick_step = q[5:0];
  endfunction : pick_step

  // step size to code, split table
  function automatic logic [4:0] step_code(logic [5:0] st);
    if (st <= STEP_UNIT)
      step_code = 5'(STEP_UNIT - st);
    else
      step_code = {1'b1, 4'(st - STEP_UNIT - 6'h01)};
  endfunction : step_code

  // centred on 32, sign picks direction
  function automatic logic [5:0] fine_code(logic signed [15:0] r,
                                           logic [5:0] st);
    logic [16:0] mag;
    logic [16:0] cnt;
    logic signed [17:0] f;
    mag = (r < 0) ? 17'(-r) : 17'(r);
    cnt = ((mag << 1) + 17'(st)) / (17'(st) << 1);
    if (r < 0)
      f = 18'(FINE_MID) - 18'(cnt);
    else
      f = 18'(FINE_MID) + 18'(cnt);
    if (f < 0)
      fine_code = 6'h00;
    else if (f > 18'(FINE_MAX))
      fine_code = 6'h3f;
    else
      fine_code = f[5:0];
  endfunction : fine_code

endpackage : rtc_trim_pkg

//--- logic/rtc_trim_if.sv
`timescale 1ns/100ps
interface rtc_trim_if;
  logic [5:0] addr;
  logic [7:0] wdata;
  logic we;
  logic re;
  logic [7:0] rdata;
  logic fout_o;
  logic fout_oe;
  logic fout_level;

  // open-drain pin with pull-up
  assign fout_level = (fout_oe && !fout_o) ? 1'b0 : 1'b1;

  modport device(
    input addr,
    input wdata,
    input we,
    input re,
    output rdata,
    output fout_o,
    output fout_oe
  );

  modport host(
    output addr,
    output wdata,
    output we,
    output re,
    input rdata,
    input fout_level
  );
endinterface : rtc_trim_if

//--- logic/rtc_trim_device.sv
`timescale 1ns/100ps
module rtc_trim_device (
  input wire logic clk_sys,
  input wire logic rst,
  rtc_trim_if.device bus,
  input wire logic signed [9:0] temp_half_c,
  output logic comp_active,
  output logic [7:0] comp_coef,
  output logic signed [9:0] turnover_half_c,
  output logic [1:0] coarse_trim,
  output logic [5:0] fine_trim
);

  typedef struct packed {
    logic [7:0] out_ctrl;
    logic [7:0] itr;
    logic [7:0] cold;
    logic [7:0] step;
    logic [7:0] turnover_temp_reg;
    logic [7:0] hot;
    logic [7:0] rdata;
    logic [12:0] div;
    logic wave;
    logic oe;
    logic active;
    logic [7:0] coef;
    logic signed [9:0] turn;
  } dev_s;

  dev_s s_q;
  dev_s s_d;

  always_comb
  begin
    s_d = s_q;
    s_d.rdata = 8'h00;
    if (bus.we)
    begin
      case (bus.addr)
        rtc_trim_pkg::OFS_OUT_CTRL: s_d.out_ctrl = bus.wdata;
        rtc_trim_pkg::OFS_ITR: s_d.itr = bus.wdata;
        rtc_trim_pkg::OFS_COLD: s_d.cold = bus.wdata;
        rtc_trim_pkg::OFS_STEP: s_d.step = bus.wdata;
        rtc_trim_pkg::OFS_XTO: s_d.turnover_temp_reg = bus.wdata;
        rtc_trim_pkg::OFS_HOT: s_d.hot = bus.wdata;
        default: ;
      endcase
    end
    if (bus.re)
    begin
      case (bus.addr)
        rtc_trim_pkg::OFS_OUT_CTRL: s_d.rdata = s_q.out_ctrl;
        rtc_trim_pkg::OFS_ITR: s_d.rdata = s_q.itr;
        rtc_trim_pkg::OFS_COLD: s_d.rdata = s_q.cold;
        rtc_trim_pkg::OFS_STEP: s_d.rdata = s_q.step;
        rtc_trim_pkg::OFS_XTO: s_d.rdata = s_q.turnover_temp_reg;
        rtc_trim_pkg::OFS_HOT: s_d.rdata = s_q.hot;
        default: s_d.rdata = 8'h00;
      endcase
    end
    // select code 0011 gives 1024 hz
    if (s_q.out_ctrl[3:0] == rtc_trim_pkg::FREQ_SEL_1024)
    begin
      if (s_q.div == 13'(rtc_trim_pkg::FOUT_HALF_CYC - 1))
      begin
        s_d.div = 13'h0000;
        s_d.wave = !s_q.wave;
      end
      else
        s_d.div = s_q.div + 13'h0001;
      // pin pulled low only during the low half
      s_d.oe = !s_q.wave;
    end
    else
    begin
      s_d.div = 13'h0000;
      s_d.wave = 1'b1;
      s_d.oe = 1'b0;
    end
    s_d.turn = rtc_trim_pkg::xto_decode(s_q.turnover_temp_reg[4:0]);
    s_d.active = s_q.step[rtc_trim_pkg::COMP_EN_BIT]
      && temp_half_c >= rtc_trim_pkg::TEMP_MIN
      && temp_half_c <= rtc_trim_pkg::TEMP_MAX;
    if (!s_d.active)
      s_d.coef = 8'h00;
    else if (temp_half_c < s_q.turn)
      s_d.coef = s_q.cold;
    else
      s_d.coef = s_q.hot;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      s_q <= '0;
      s_q.out_ctrl <= rtc_trim_pkg::RST_OUT_CTRL;
      s_q.itr <= rtc_trim_pkg::RST_ITR;
      s_q.cold <= rtc_trim_pkg::RST_COEF;
      s_q.hot <= rtc_trim_pkg::RST_COEF;
      s_q.step <= rtc_trim_pkg::RST_STEP;
      s_q.turnover_temp_reg <= rtc_trim_pkg::RST_XTO;
      s_q.wave <= 1'b1;
      s_q.turn <= rtc_trim_pkg::TURN_BASE;
    end
    else
      s_q <= s_d;
  end

  // step register only supplies the enable bit here, reported as stored
  assign bus.rdata = s_q.rdata;
  assign bus.fout_o = 1'b0;
  assign bus.fout_oe = s_q.oe;
  assign comp_active = s_q.active;
  assign comp_coef = s_q.coef;
  assign turnover_half_c = s_q.turn;
  assign coarse_trim = s_q.itr[7:6];
  assign fine_trim = s_q.itr[5:0];

endmodule : rtc_trim_device

//--- logic/rtc_trim_host.sv
`timescale 1ns/100ps
// How it works
// - trim byte: coarse top two, fine six
// - error above +31: coarse 11, minus 30.5
// - error below -32: coarse 01, plus 30.5
// - otherwise coarse 00, error unchanged
// - step count: rounded error over step
// - fine trim is 32 minus/plus count
// - step code nearest measured step size
// - turnover code maps half degrees
// - turnover code written at 0x2c
// - scaled curvature to both coefficient registers
// - compensation enable written last
// - select 0011 gives 1024 hz
// - step size is extremes span over 63
// - measure with mid trim 0x20; host writes the trim byte from start bits 15:8
// - bit 7 of 0x0d enables compensation
// - cold below turnover, hot above
module rtc_trim_host #(
  parameter int GATE_CYCLES = rtc_trim_pkg::GATE_CYC
) (
  input wire logic clk_sys,
  input wire logic rst,
  rtc_trim_if.host bus,
  input wire logic [2:0] sw_addr,
  input wire logic [15:0] sw_wdata,
  input wire logic sw_we,
  input wire logic sw_re,
  output logic [15:0] sw_rdata
);

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_CALC = 5'b00010,
    ST_WRITE = 5'b00100,
    ST_VERIFY = 5'b01000,
    ST_COUNT = 5'b10000
  } state_e;

  typedef struct packed {
    state_e st;
    logic meas;
    logic [2:0] idx;
    logic signed [15:0] f1;
    logic signed [15:0] f2;
    logic signed [15:0] f3;
    logic signed [9:0] turn;
    logic [15:0] alpha;
    logic [1:0] batt;
    logic [7:0] meas_itr;
    logic [4:0] beta;
    logic [1:0] coarse;
    logic [5:0] fine;
    logic [7:0] scaled;
    logic done;
    logic ok;
    logic chk;
    logic [15:0] rdata;
    logic [5:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
    logic [2:0] sync;
    logic lvl;
    logic [23:0] gate;
    logic [15:0] edges;
  } host_s;

  host_s s_q;
  host_s s_d;

  always_comb
  begin
    logic signed [15:0] rem;
    logic [5:0] st;
    logic [15:0] sc;
    rem = s_q.f3;
    st = 6'h00;
    sc = 16'h0000;
    s_d = s_q;
    s_d.we = 1'b0;
    s_d.re = 1'b0;
    s_d.sync = {s_q.sync[1:0], bus.fout_level};
    // level moves once the last two stages agree
    if (s_q.sync[1] == s_q.sync[2])
      s_d.lvl = s_q.sync[2];
    if (sw_we)
    begin
      case (sw_addr)
        3'h0:
        begin
          if (s_q.st == ST_IDLE && (sw_wdata[0] || sw_wdata[1]))
          begin
            s_d.meas = !sw_wdata[0];
            s_d.batt = sw_wdata[3:2];
            s_d.meas_itr = sw_wdata[15:8];
            s_d.done = 1'b0;
            s_d.ok = 1'b0;
            s_d.idx = 3'h0;
            s_d.st = sw_wdata[0] ? ST_CALC : ST_WRITE;
          end
        end
        3'h1: s_d.f1 = sw_wdata;
        3'h2: s_d.f2 = sw_wdata;
        3'h3: s_d.f3 = sw_wdata;
        3'h4: s_d.turn = 10'(signed'(sw_wdata));
        3'h5: s_d.alpha = sw_wdata;
        default: ;
      endcase
    end
    if (sw_re)
    begin
      case (sw_addr)
        3'h0: s_d.rdata = {13'h0000, s_q.ok, s_q.done,
                           s_q.st != ST_IDLE};
        3'h1: s_d.rdata = s_q.f1;
        3'h2: s_d.rdata = s_q.f2;
        3'h3: s_d.rdata = s_q.f3;
        3'h4: s_d.rdata = 16'(s_q.turn);
        3'h5: s_d.rdata = s_q.alpha;
        3'h6: s_d.rdata = {3'h0, s_q.beta, s_q.coarse, s_q.fine};
        3'h7: s_d.rdata = s_q.edges;
        default: s_d.rdata = 16'h0000;
      endcase
    end
    case (s_q.st)
      ST_IDLE: ;
      ST_CALC:
      begin
        st = rtc_trim_pkg::pick_step(s_q.f1, s_q.f2);
        s_d.beta = rtc_trim_pkg::step_code(st);
        if (s_q.f3 > rtc_trim_pkg::COARSE_HI)
        begin
          s_d.coarse = rtc_trim_pkg::COARSE_UP;
          rem = s_q.f3 - rtc_trim_pkg::COARSE_STEP;
        end
        else if (s_q.f3 < rtc_trim_pkg::COARSE_LO)
        begin
          s_d.coarse = rtc_trim_pkg::COARSE_DOWN;
          rem = s_q.f3 + rtc_trim_pkg::COARSE_STEP;
        end
        else
          s_d.coarse = rtc_trim_pkg::COARSE_NONE;
        s_d.fine = rtc_trim_pkg::fine_code(rem, st);
        // times 2048, rounded; 17 bits so the sum cannot wrap
        sc = 16'((17'(s_q.alpha) + 17'(rtc_trim_pkg::ALPHA_ROUND))
          >> rtc_trim_pkg::ALPHA_SHIFT);
        s_d.scaled = (sc > 16'h00ff) ? 8'hff : sc[7:0];
        s_d.st = ST_WRITE;
      end
      ST_WRITE:
      begin
        s_d.we = 1'b1;
        s_d.idx = s_q.idx + 3'h1;
        // output select, step, trim, turnover, coefs, enable
        case (s_q.idx)
          3'h0:
          begin
            // 1024 hz on the output pin
            s_d.addr = rtc_trim_pkg::OFS_OUT_CTRL;
            s_d.wdata = rtc_trim_pkg::OUT_CTRL_1024;
            if (s_q.meas)
              s_d.idx = 3'h7;
          end
          3'h1:
          begin
            s_d.addr = rtc_trim_pkg::OFS_STEP;
            s_d.wdata = {3'h0, s_q.beta};
          end
          3'h2:
          begin
            s_d.addr = rtc_trim_pkg::OFS_ITR;
            s_d.wdata = {s_q.coarse, s_q.fine};
          end
          3'h3:
          begin
            s_d.addr = rtc_trim_pkg::OFS_XTO;
            s_d.wdata = {3'h0, rtc_trim_pkg::xto_encode(s_q.turn)};
          end
          3'h4:
          begin
            s_d.addr = rtc_trim_pkg::OFS_COLD;
            s_d.wdata = s_q.scaled;
          end
          3'h5:
          begin
            s_d.addr = rtc_trim_pkg::OFS_HOT;
            s_d.wdata = s_q.scaled;
          end
          3'h6:
          begin
            s_d.addr = rtc_trim_pkg::OFS_STEP;
            s_d.wdata = {1'b1, s_q.batt, s_q.beta};
            s_d.st = ST_VERIFY;
            s_d.chk = 1'b0;
          end
          default:
          begin
            // trim byte for measuring, 0x20 for mid scale
            s_d.addr = rtc_trim_pkg::OFS_ITR;
            s_d.wdata = s_q.meas_itr;
            s_d.gate = 24'(GATE_CYCLES);
            s_d.edges = 16'h0000;
            s_d.st = ST_COUNT;
          end
        endcase
      end
      ST_VERIFY:
      begin
        // read back the enable register, compare a cycle later
        if (!s_q.chk)
        begin
          s_d.re = 1'b1;
          s_d.chk = 1'b1;
        end
        else if (!s_q.re)
        begin
          s_d.ok = (bus.rdata == s_q.wdata);
          s_d.done = 1'b1;
          s_d.st = ST_IDLE;
        end
      end
      ST_COUNT:
      begin
        if (s_d.lvl && !s_q.lvl && s_q.edges != 16'hffff)
          s_d.edges = s_q.edges + 16'h0001;
        s_d.gate = s_q.gate - 24'h000001;
        if (s_q.gate == 24'h000001)
        begin
          s_d.done = 1'b1;
          s_d.st = ST_IDLE;
        end
      end
      default: s_d.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      s_q <= '0;
      s_q.st <= ST_IDLE;
      s_q.sync <= 3'h7;
      s_q.lvl <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  assign bus.addr = s_q.addr;
  assign bus.wdata = s_q.wdata;
  assign bus.we = s_q.we;
  assign bus.re = s_q.re;
  assign sw_rdata = s_q.rdata;

endmodule : rtc_trim_host

//--- verification/rtc_trim_assertions.sv
`timescale 1ns/100ps
module rtc_trim_assertions (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [5:0] addr,
  input wire logic [7:0] wdata,
  input wire logic we,
  input wire logic re,
  input wire logic [7:0] rdata,
  input wire logic fout_o,
  input wire logic fout_oe
);
  logic [15:0] low_run_q;
  logic [15:0] low_run_d;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // length of the current pulled-low stretch
  always_comb
  begin
    low_run_d = fout_oe ? low_run_q + 16'h0001 : 16'h0000;
  end
  always_ff @(posedge clk_sys)
  begin
    low_run_q <= rst ? 16'h0000 : low_run_d;
  end

  sequence s_wr_itr; we && addr == rtc_trim_pkg::OFS_ITR; endsequence
  sequence s_wr_xto; we && addr == rtc_trim_pkg::OFS_XTO; endsequence
  sequence s_wr_cold; we && addr == rtc_trim_pkg::OFS_COLD; endsequence
  sequence s_wr_hot; we && addr == rtc_trim_pkg::OFS_HOT; endsequence
  sequence s_enable;
    we && addr == rtc_trim_pkg::OFS_STEP && wdata[rtc_trim_pkg::COMP_EN_BIT];
  endsequence

  property p_strobes_apart; !(we && re); endproperty
  property p_rdata_idle; !re |=> rdata == 8'h00; endproperty
  property p_order;
    s_wr_itr ##1 s_wr_xto |=> s_wr_cold ##1 s_wr_hot ##1 s_enable;
  endproperty
  property p_coef_same; s_wr_cold |=> we && wdata == $past(wdata); endproperty
  property p_enable_last;
    s_enable |-> $past(we) && $past(addr) == rtc_trim_pkg::OFS_HOT;
  endproperty
  property p_verify_read;
    s_enable |=> re && addr == rtc_trim_pkg::OFS_STEP ##1
      rdata == $past(wdata, 2);
  endproperty
  property p_step_code;
    we && addr == rtc_trim_pkg::OFS_STEP |-> wdata[4] || wdata[3:0] <= 4'h8;
  endproperty
  property p_xto_code; s_wr_xto |-> wdata[7:5] == 3'h0; endproperty
  property p_out_sel;
    we && addr == rtc_trim_pkg::OFS_OUT_CTRL |->
      wdata == rtc_trim_pkg::OUT_CTRL_1024;
  endproperty
  property p_half_period;
    fout_oe |-> low_run_q < 16'(rtc_trim_pkg::FOUT_HALF_CYC) && !fout_o;
  endproperty

  a_strobes_apart: assert property (p_strobes_apart)
    else $error("write and read strobes together");
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not zero outside answer cycle");
  a_order: assert property (p_order)
    else $error("trim writes out of order");
  a_coef_same: assert property (p_coef_same)
    else $error("hot coefficient differs from cold");
  a_enable_last: assert property (p_enable_last)
    else $error("enable written before coefficients");
  a_verify_read: assert property (p_verify_read)
    else $error("step register readback wrong");
  a_step_code: assert property (p_step_code)
    else $error("step code outside table");
  a_xto_code: assert property (p_xto_code)
    else $error("turnover code too wide");
  a_out_sel: assert property (p_out_sel)
    else $error("output select not 1024 hz");
  a_half_period: assert property (p_half_period)
    else $error("pin held low too long");
endmodule : rtc_trim_assertions

//--- verification/rtc_crystal_trim_calibration_tb.sv
`timescale 1ns/100ps
module rtc_crystal_trim_calibration_tb;
  logic clk_sys;
  logic rst;
  logic [2:0] sw_addr;
  logic [15:0] sw_wdata;
  logic sw_we;
  logic sw_re;
  logic [15:0] sw_rdata;
  logic signed [9:0] temp_half_c;
  logic comp_active;
  logic [7:0] comp_coef;
  logic signed [9:0] turnover_half_c;
  logic [1:0] coarse_trim;
  logic [5:0] fine_trim;
  logic [7:0] last_itr, last_xto, last_step, last_hot;
  int mismatches;
  int comparisons;

  rtc_trim_if bus ();
  rtc_trim_device rtc_trim_device_inst (.clk_sys(clk_sys), .rst(rst),
    .bus(bus), .temp_half_c(temp_half_c), .comp_active(comp_active),
    .comp_coef(comp_coef), .turnover_half_c(turnover_half_c),
    .coarse_trim(coarse_trim), .fine_trim(fine_trim));
  // short gate keeps each measurement near two pin periods
  rtc_trim_host #(.GATE_CYCLES(20000)) rtc_trim_host_inst (.clk_sys(clk_sys),
    .rst(rst), .bus(bus), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
    .sw_we(sw_we), .sw_re(sw_re), .sw_rdata(sw_rdata));
  rtc_trim_assertions rtc_trim_assertions_inst (.clk_sys(clk_sys),
    .rst(rst), .addr(bus.addr), .wdata(bus.wdata), .we(bus.we),
    .re(bus.re), .rdata(bus.rdata), .fout_o(bus.fout_o),
    .fout_oe(bus.fout_oe));

  // wire monitor: last byte written to the itr, turnover, step and hot registers
  always @(posedge clk_sys)
  begin
    if (bus.we && bus.addr == rtc_trim_pkg::OFS_ITR) last_itr <= bus.wdata;
    if (bus.we && bus.addr == rtc_trim_pkg::OFS_XTO) last_xto <= bus.wdata;
    if (bus.we && bus.addr == rtc_trim_pkg::OFS_STEP) last_step <= bus.wdata;
    if (bus.we && bus.addr == rtc_trim_pkg::OFS_HOT) last_hot <= bus.wdata;
  end

  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_sim

  task automatic check(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic sw_wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    sw_addr <= a;
    sw_wdata <= d;
    sw_we <= 1'b1;
    @(posedge clk_sys);
    sw_we <= 1'b0;
  endtask : sw_wr

  task automatic sw_rd(input logic [2:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    sw_addr <= a;
    sw_re <= 1'b1;
    @(posedge clk_sys);
    sw_re <= 1'b0;
    #1;
    d = sw_rdata;
  endtask : sw_rd

  // done with busy low, so a stale done is not taken
  task automatic wait_done;
    logic [15:0] st;
    int n;
    n = 0;
    st = 16'h0001;
    while (st[0] !== 1'b0 || st[1] !== 1'b1)
    begin
      sw_rd(3'h0, st);
      n++;
      if (n > 12000)
      begin
        mismatches++;
        end_sim();
      end
    end
  endtask : wait_done

  task automatic cal(input logic [15:0] f1, f2, f3, turn, alpha, ctrl,
                     input logic [7:0] e_step, e_itr, e_xto, e_coef);
    logic [15:0] rd;
    sw_wr(3'h1, f1);
    sw_wr(3'h2, f2);
    sw_wr(3'h3, f3);
    sw_wr(3'h4, turn);
    sw_wr(3'h5, alpha);
    sw_wr(3'h0, ctrl);
    wait_done();
    sw_rd(3'h0, rd);
    check("verify_ok", {15'h0, rd[2]}, 16'h0001);
    check("step_wr", {8'h0, last_step}, {8'h0, e_step});
    check("itr_wr", {8'h0, last_itr}, {8'h0, e_itr});
    check("itr_dev", {8'h0, coarse_trim, fine_trim},
          {8'h0, e_itr});
    check("xto_wr", {8'h0, last_xto}, {8'h0, e_xto});
    check("turnover", {6'h0, turnover_half_c}, {6'h0, turn[9:0]});
    check("hot_wr", {8'h0, last_hot}, {8'h0, e_coef});
    check("active", {15'h0, comp_active}, 16'h0001);
    check("coef", {8'h0, comp_coef}, {8'h0, e_coef});
    sw_rd(3'h6, rd);
    check("result", {3'h0, rd[12:0]},
          {3'h0, e_step[4:0], e_itr});
    $display("test calibrate itr %h done", e_itr);
  endtask : cal

  task automatic temp_range;
    logic signed [9:0] t [4];
    t = '{-10'sd81, -10'sd80, 10'sd170, 10'sd171};
    foreach (t[i])
    begin
      @(posedge clk_sys);
      temp_half_c <= t[i];
      repeat (3) @(posedge clk_sys);
      #1;
      check("t_active", {15'h0, comp_active}, {15'h0, i[0] ^ i[1]});
      check("t_coef", {8'h0, comp_coef},
            {8'h0, (i[0] ^ i[1]) ? last_hot : 8'h00});
    end
    @(posedge clk_sys);
    temp_half_c <= 10'sd50;
    $display("test temperature range done");
  endtask : temp_range

  task automatic measure;
    logic [7:0] tb [2];
    logic [15:0] rd;
    int n;
    tb = '{8'h3f, 8'h20};
    foreach (tb[i])
    begin
      sw_wr(3'h0, {tb[i], 8'h02});
      wait_done();
      check("meas_itr", {8'h0, last_itr}, {8'h0, tb[i]});
      sw_rd(3'h7, rd);
      // a 20000 cycle gate spans just over two pin periods, two or three rising edges
      check("edges", {15'h0, rd == 16'h0002 || rd == 16'h0003},
            16'h0001);
    end
    n = 0;
    while (bus.fout_level !== 1'b1 && n < 20000)
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    while (bus.fout_level !== 1'b0 && n < 20000)
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    if (n >= 20000)
    begin
      mismatches++;
      end_sim();
    end
    n = 0;
    while (bus.fout_level === 1'b0 && n < 20000)
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    check("low_half", 16'(n), 16'(rtc_trim_pkg::FOUT_HALF_CYC));
    $display("test measure done");
  endtask : measure

  initial
  begin
    rst = 1'b1;
    sw_addr = 3'h0;
    sw_wdata = 16'h0000;
    sw_we = 1'b0;
    sw_re = 1'b0;
    temp_half_c = 10'sd50;
    mismatches = 0;
    comparisons = 0;
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    #1;
    check("rst_itr", {8'h0, coarse_trim, fine_trim},
          {8'h0, rtc_trim_pkg::RST_ITR});
    check("rst_active", {15'h0, comp_active}, 16'h0000);
    $display("test reset done");
    cal(16'h0095, 16'hfc0a, 16'hfe40, 16'h0032, 16'h08b4, 16'h0001,
        8'h91, 8'h07, 8'h00, 8'h46);
    // both start bits set: calibrate must win over measure
    cal(16'h01f8, 16'hfe08, 16'h0280, 16'h0040, 16'h0fa0, 16'h0003,
        8'h80, 8'hea, 8'h0e, 8'h7d);
    cal(16'h01f8, 16'hfe08, 16'hfd80, 16'h0023, 16'h3e80, 16'h0001,
        8'h80, 8'h56, 8'h1f, 8'hff);
    cal(16'h00fc, 16'hff04, 16'h01f0, 16'h0032, 16'h08b4, 16'h000d,
        8'he8, 8'h3f, 8'h00, 8'h46);
    temp_range();
    measure();
    end_sim();
  end
endmodule : rtc_crystal_trim_calibration_tb
